// >>> logic/ssu_pkg.sv
// Purpose: constants and carrier types for the serial shift unit
// Assumes: 10 MHz ref_clk, serial clock pin arrives as its own clock
// Notes: wire mode and clock source encodings follow the control fields
//
// Summary of operation
// - eight-bit shift data register, readable and writable, no holding buffer.
// - msb of the shift register drives one of two pins by wire mode.
// - latch between register and pin moves output on opposite clock edge.
// - serial input always comes from the serial input pin.
// - four-bit counter readable and writable, overflow raises an interrupt request.
// - shift register and counter share one clock source.
// - external clock source increments the counter on both edges.
// - shift clock from serial clock pin, timer match or software strobe.
// - two-wire start detect and clock held low after start or overflow.
// - three-wire mode works as spi modes 0 and 1, no slave select.
// - eight serial clocks swap master and slave register contents.
// - toggle strobe write flips the serial clock pin; port write also sets it.
// - mode 0 samples rising, shifts falling; mode 1 the opposite edges.
// - sixteen external edges overflow the counter and set the overflow flag.
// - counter overflow request wakes the processor from idle.
// - status write with flag bit set clears flag and loads counter.
// - external source with clock strobe counts on each toggle strobe.
// - alternating toggle and toggle-plus-clock writes give half-rate master clocking.
// - data write in the same cycle as a clock event wins, no shift.
package ssu_pkg;

    // wire modes
    localparam logic [1:0] WM_NONE = 2'h0;
    localparam logic [1:0] WM_THREE = 2'h1;
    localparam logic [1:0] WM_TWO = 2'h2;
    localparam logic [1:0] WM_TWO_HOLD = 2'h3;

    // clock sources; high bit selects the external pin
    localparam logic [1:0] CS_SOFT = 2'h0;
    localparam logic [1:0] CS_TIMER = 2'h1;

    // reset values and counter limits
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // sync vector bit positions
    localparam int SY_POS = 0;
    localparam int SY_NEG = 1;
    localparam int SY_SDI = 2;
    localparam int SY_SCK = 3;

    // control register write
    typedef struct packed {
        logic [1:0] wire_mode;
        logic [1:0] clk_src;
        logic clock_strobe;
        logic clock_toggle_strobe;
    } ssu_ctrl_s;

    // status register write
    typedef struct packed {
        logic start_clear;
        logic ovf_clear;
        logic [3:0] count;
    } ssu_stat_s;

    // serial pin drive group
    typedef struct packed {
        logic data_out;
        logic data_oe;
        logic sda_out;
        logic sda_oe;
        logic sck_out;
        logic sck_oe;
    } ssu_pins_s;

endpackage : ssu_pkg

// >>> logic/ssu_top.sv
// Purpose: serial shift unit, three-wire operation with two-wire hooks
// Assumes: serial_clock_pin is the pin level, used as link clock and level
// Notes: software side is plain strobes; outputs all come from flops
`timescale 1ns/100ps
module ssu_top (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic serial_clock_pin,
    input wire logic serial_in_pin,
    input wire logic ctrl_wr,
    input wire ssu_pkg::ssu_ctrl_s ctrl_wdata,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    input wire logic stat_wr,
    input wire ssu_pkg::ssu_stat_s stat_wdata,
    input wire logic timer_match,
    input wire logic port_sck_wr,
    input wire logic port_sck_val,
    input wire logic data_out_dir,
    input wire logic clock_out_dir,
    input wire logic ovf_irq_en,
    output logic [7:0] shift_data_reg,
    output logic [3:0] count_value,
    output logic count_overflow_flag,
    output logic start_flag,
    output logic ovf_irq,
    output ssu_pkg::ssu_pins_s pins
);

    // link domain: one toggle and one captured bit per pin edge
    logic pos_tog;
    logic pos_bit;
    logic neg_tog;
    logic neg_bit;

    // ref domain state
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    ssu_pkg::ssu_ctrl_s ctrl;
    logic out_latch;
    logic sck_level;
    logic start_hold;

    // sample on rising edge of the pin clock
    always_ff @(posedge serial_clock_pin or negedge nrst) begin
        if (!nrst) begin
            pos_tog <= 1'b0;
            pos_bit <= 1'b0;
        end else begin
            pos_tog <= ~pos_tog;
            pos_bit <= serial_in_pin;
        end
    end

    // sample on falling edge of the pin clock
    always_ff @(negedge serial_clock_pin or negedge nrst) begin
        if (!nrst) begin
            neg_tog <= 1'b0;
            neg_bit <= 1'b0;
        end else begin
            neg_tog <= ~neg_tog;
            neg_bit <= serial_in_pin;
        end
    end

    // two-flop sync of toggles and pin levels, third stage for edge detect
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {serial_clock_pin, serial_in_pin, neg_tog, pos_tog};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // edge events and clock source decode
    wire pos_evt = sync2[ssu_pkg::SY_POS] ^ sync3[ssu_pkg::SY_POS];
    wire neg_evt = sync2[ssu_pkg::SY_NEG] ^ sync3[ssu_pkg::SY_NEG];
    wire sdi_s = sync2[ssu_pkg::SY_SDI];
    wire sdi_d = sync3[ssu_pkg::SY_SDI];
    wire sck_s = sync2[ssu_pkg::SY_SCK];
    wire ext_sel = ctrl.clk_src[1];
    wire mode_one = ctrl.clk_src[0];
    wire two_wire = ctrl.wire_mode[1];

    // mode 0 samples rising, mode 1 falling; the other edge moves output
    wire sample_evt = ext_sel & (mode_one ? neg_evt : pos_evt);
    // captured bit is quasi-static: held a full link period past its toggle
    wire ext_bit = mode_one ? neg_bit : pos_bit;
    wire soft_tick = ctrl_wr & ctrl_wdata.clock_strobe
        & (ctrl_wdata.clk_src == ssu_pkg::CS_SOFT);
    wire timer_tick = (ctrl.clk_src == ssu_pkg::CS_TIMER) & timer_match;
    wire tgl_tick = ctrl_wr & ctrl_wdata.clock_toggle_strobe;
    wire strobe_count = tgl_tick & ctrl_wdata.clk_src[1] & ctrl_wdata.clock_strobe;
    wire edge_count = ext_sel & ~ctrl.clock_strobe & (pos_evt | neg_evt);
    wire shift_tick = soft_tick | timer_tick | sample_evt;
    wire cnt_tick = soft_tick | timer_tick | edge_count | strobe_count;
    wire in_bit = ext_sel ? ext_bit : sdi_s;

    // data register next value: a write beats a shift in the same cycle
    wire [7:0] shifted = {shift_data_reg[6:0], in_bit};
    wire [7:0] next_data = data_wr ? data_wdata
        : (shift_tick ? shifted : shift_data_reg);

    // counter, overflow and flag: a status write wins over the hardware set
    wire ovf_evt = cnt_tick & (count_value == ssu_pkg::CNT_MAX) & ~stat_wr;
    wire [3:0] next_count = stat_wr ? stat_wdata.count
        : (cnt_tick ? 4'(count_value + ssu_pkg::CNT_ONE) : count_value);
    wire flag_clr = stat_wr & stat_wdata.ovf_clear;
    wire next_flag = ovf_evt | (count_overflow_flag & ~flag_clr);

    // start condition: data falls while clock stays high, two-wire only
    wire start_evt = two_wire & sdi_d & ~sdi_s & sck_s;
    wire start_clr = stat_wr & stat_wdata.start_clear;
    wire next_start = start_evt | (start_flag & ~start_clr);
    wire next_start_hold = next_start & (start_hold | (start_flag & ~sck_s));
    wire hold_low = two_wire & (start_hold
        | ((ctrl.wire_mode == ssu_pkg::WM_TWO_HOLD) & count_overflow_flag));

    // latch open while the pin clock sits in its output phase
    wire latch_open = ~ext_sel | (mode_one ? sck_s : ~sck_s);
    wire next_latch = latch_open ? shift_data_reg[7] : out_latch;

    // clock pin level: toggle strobe flips it, port write sets it
    wire next_sck = tgl_tick ? ~sck_level
        : (port_sck_wr ? port_sck_val : sck_level);

    // pin drive; three-wire has no slave select, select is left to software
    ssu_pkg::ssu_pins_s next_pins;
    always_comb begin
        next_pins = '0;
        next_pins.data_out = out_latch;
        next_pins.data_oe = data_out_dir & (ctrl.wire_mode == ssu_pkg::WM_THREE);
        next_pins.sda_out = 1'b0;
        next_pins.sda_oe = two_wire & data_out_dir & ~out_latch;
        next_pins.sck_out = sck_level & ~hold_low;
        next_pins.sck_oe = clock_out_dir | hold_low;
    end

    // control register
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl <= '0;
        end else if (ctrl_wr) begin
            ctrl <= ctrl_wdata;
        end
    end

    // shift register and counter
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            shift_data_reg <= ssu_pkg::DATA_RST;
            count_value <= ssu_pkg::CNT_RST;
        end else begin
            shift_data_reg <= next_data;
            count_value <= next_count;
        end
    end

    // flags and the request that also serves as idle wake
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_overflow_flag <= 1'b0;
            ovf_irq <= 1'b0;
            start_flag <= 1'b0;
            start_hold <= 1'b0;
        end else begin
            count_overflow_flag <= next_flag;
            ovf_irq <= next_flag & ovf_irq_en;
            start_flag <= next_start;
            start_hold <= next_start_hold;
        end
    end

    // output latch, clock level and registered pins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_latch <= 1'b0;
            sck_level <= 1'b0;
            pins <= '0;
        end else begin
            out_latch <= next_latch;
            sck_level <= next_sck;
            pins <= next_pins;
        end
    end

    // write wins over any serial clock event
    a_data_write_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
        data_wr |=> shift_data_reg == $past(data_wdata))
        else $error("data write lost to a shift");

    // wrap from fifteen sets the flag in the same step
    a_count_wrap_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cnt_tick && !stat_wr && count_value == 4'hF)
        |=> (count_value == 4'h0 && count_overflow_flag))
        else $error("counter wrap did not set flag");

    // flag sticks until software clears it
    a_flag_stays_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        (count_overflow_flag && !(stat_wr && stat_wdata.ovf_clear))
        |=> count_overflow_flag [*1])
        else $error("overflow flag dropped without clear");

    // status write clears flag and loads counter
    a_status_clear_load: assert property (@(posedge ref_clk) disable iff (!nrst)
        (stat_wr && stat_wdata.ovf_clear)
        |=> (!count_overflow_flag && count_value == $past(stat_wdata.count)))
        else $error("status write did not clear and load");

    // software strobe shifts in the synced input and counts once
    a_soft_shift_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (soft_tick && !data_wr && !stat_wr)
        |=> (shift_data_reg == {$past(shift_data_reg[6:0]), $past(sdi_s)}
            && count_value == $past(count_value) + 4'h1))
        else $error("software strobe shift or count wrong");

    // external source counts both pin edges
    a_ext_edge_count: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ext_sel && !ctrl.clock_strobe && (pos_evt || neg_evt) && !stat_wr && !ctrl_wr)
        |=> count_value == $past(count_value) + 4'h1)
        else $error("external edge not counted");

    // toggle strobe flips the clock pin two edges later
    a_toggle_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tgl_tick && !hold_low) ##1 !hold_low
        |=> pins.sck_out == !$past(sck_level, 2))
        else $error("clock pin did not toggle");

    // msb reaches the data pin through the latch when it is open
    a_msb_to_pin: assert property (@(posedge ref_clk) disable iff (!nrst)
        (!ext_sel && !ctrl_wr) ##1 !ctrl_wr |=> pins.data_out == $past(shift_data_reg[7], 2))
        else $error("msb did not reach the data pin");

    // latch holds while the pin clock is in the sampling phase
    a_latch_closed: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ext_sel && !latch_open) |=> out_latch == $past(out_latch))
        else $error("output latch moved in sampling phase");

    // held clock line is driven low
    a_two_wire_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        hold_low |=> (pins.sck_oe && !pins.sck_out))
        else $error("clock not held low");

    // request tracks the sticky flag under its enable, one edge behind the enable
    a_irq_follows_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        ovf_irq == (count_overflow_flag && $past(ovf_irq_en)))
        else $error("overflow request does not follow flag");

    // a detected start condition is remembered
    a_start_sets_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
        start_evt |=> start_flag)
        else $error("start condition not flagged");

    // three-wire mode drives the data pin when its direction bit says so
    a_three_wire_oe: assert property (@(posedge ref_clk) disable iff (!nrst)
        (ctrl.wire_mode == ssu_pkg::WM_THREE && data_out_dir) |=> pins.data_oe)
        else $error("data pin not driven in three-wire mode");

    // strobe counting with external source advances the counter once
    a_strobe_counts: assert property (@(posedge ref_clk) disable iff (!nrst)
        (strobe_count && !stat_wr) |=> count_value == $past(count_value) + 4'h1)
        else $error("toggle strobe not counted");

    // timer match shifts the synced input in unless a data write collides
    a_timer_shift: assert property (@(posedge ref_clk) disable iff (!nrst)
        (timer_tick && !data_wr)
        |=> shift_data_reg == {$past(shift_data_reg[6:0]), $past(sdi_s)})
        else $error("timer match did not shift");

    c_overflow: cover property (@(posedge ref_clk) disable iff (!nrst) ovf_evt);
    c_ext_sample: cover property (@(posedge ref_clk) disable iff (!nrst) sample_evt);
    c_start_seen: cover property (@(posedge ref_clk) disable iff (!nrst) start_evt);
    c_write_vs_shift: cover property (@(posedge ref_clk) disable iff (!nrst)
        data_wr && shift_tick);

endmodule : ssu_top

// >>> sim/ssu_peer.sv
// Purpose: far-side spi peer for the serial shift unit, master or slave role
// Assumes: spi modes 0 and 1, clock idles low, msb first
// Notes: link clock runs at 125 ns; clock edges spaced four link periods apart
`timescale 1ns/100ps
module ssu_peer (
    input wire logic sck,
    input wire logic dout,
    input wire logic mode1,
    output logic sck_drv,
    output logic sdi
);
    logic link_clk;
    logic [7:0] preg;

    // free link oscillator; the pin itself only moves inside frames
    initial begin
        link_clk = 1'b0;
        sck_drv = 1'b0;
        sdi = 1'b1;
        preg = 8'h00;
        forever #62.5 link_clk = ~link_clk;
    end

    // sample on one edge, move data on the other, by mode
    always @(posedge sck) begin
        if (!mode1) preg <= {preg[6:0], dout};
        else sdi <= preg[7];
    end
    always @(negedge sck) begin
        if (mode1) preg <= {preg[6:0], dout};
        else sdi <= preg[7];
    end

    // data set up well before the first sampling edge
    task automatic load(input logic [7:0] tx);
        preg = tx;
        sdi = tx[7];
    endtask : load

    // drive both lines directly, for the two-wire start and hold case
    task automatic set_lines(input logic c, input logic d);
        sck_drv = c;
        sdi = d;
    endtask : set_lines

    // eight pulses; wide spacing keeps edges apart for the design's sync
    task automatic clock_byte();
        repeat (8) begin
            repeat (4) @(posedge link_clk);
            sck_drv = 1'b1;
            repeat (4) @(posedge link_clk);
            sck_drv = 1'b0;
        end
        repeat (4) @(posedge link_clk);
    endtask : clock_byte
endmodule : ssu_peer

// >>> sim/serial_shift_unit_three_wire_tb.sv
// Purpose: self-checking bench for the serial shift unit
// Assumes: peer model on the pins, strobes driven at rising ref_clk
// Notes: serial input bits from fast soft clocking are not checked
`timescale 1ns/100ps
module serial_shift_unit_three_wire_tb;
    typedef struct {
        logic [1:0] cs;
        logic [7:0] dev_tx;
        logic [7:0] peer_tx;
    } ssu_row_s;
    logic ref_clk, nrst, ctrl_wr, data_wr, stat_wr, timer_match;
    logic clock_out_dir, ovf_irq_en, peer_sck, peer_sdi, mode1, sck_wire;
    logic count_overflow_flag, start_flag, ovf_irq;
    logic [7:0] data_wdata, shift_data_reg;
    logic [3:0] count_value;
    ssu_pkg::ssu_ctrl_s ctrl_wdata;
    ssu_pkg::ssu_stat_s stat_wdata;
    ssu_pkg::ssu_pins_s pins;
    int fail_count, samples_checked, cycles;
    ssu_row_s rows [4] = '{'{2'h2, 8'hA5, 8'h3C}, '{2'h2, 8'h00, 8'hFF},
        '{2'h3, 8'h81, 8'h7E}, '{2'h3, 8'hFF, 8'h00}};

    // resolved clock wire: device wins while its driver is on
    assign sck_wire = pins.sck_oe ? pins.sck_out : peer_sck;

    ssu_top dut (.ref_clk(ref_clk), .nrst(nrst), .serial_clock_pin(sck_wire),
        .serial_in_pin(peer_sdi), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
        .data_wr(data_wr), .data_wdata(data_wdata), .stat_wr(stat_wr),
        .stat_wdata(stat_wdata), .timer_match(timer_match), .port_sck_wr(1'b0),
        .port_sck_val(1'b0), .data_out_dir(1'b1), .clock_out_dir(clock_out_dir),
        .ovf_irq_en(ovf_irq_en), .shift_data_reg(shift_data_reg),
        .count_value(count_value), .count_overflow_flag(count_overflow_flag),
        .start_flag(start_flag), .ovf_irq(ovf_irq), .pins(pins));
    ssu_peer peer (.sck(sck_wire), .dout(pins.data_out), .mode1(mode1),
        .sck_drv(peer_sck), .sdi(peer_sdi));

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic finish_test();
        if (fail_count == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // hang guard, well above the several hundred cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            finish_test();
        end
    end

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_byte

    // each strobe is one pulse, and a free edge separates two of them
    task automatic ctl(input logic [1:0] cs, input logic clk, input logic tog);
        @(posedge ref_clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= '{ssu_pkg::WM_THREE, cs, clk, tog};
        @(posedge ref_clk);
        ctrl_wr <= 1'b0;
    endtask : ctl
    task automatic dwr(input logic [7:0] v);
        @(posedge ref_clk);
        data_wr <= 1'b1;
        data_wdata <= v;
        @(posedge ref_clk);
        data_wr <= 1'b0;
    endtask : dwr
    task automatic swr(input logic [3:0] c);
        @(posedge ref_clk);
        stat_wr <= 1'b1;
        stat_wdata <= '{1'b0, 1'b1, c};
        @(posedge ref_clk);
        stat_wr <= 1'b0;
    endtask : swr
    task automatic tick();
        @(posedge ref_clk);
        timer_match <= 1'b1;
        @(posedge ref_clk);
        timer_match <= 1'b0;
    endtask : tick
    task automatic wait_chk(input logic [7:0] d, input logic [3:0] c, input logic f);
        repeat (4) @(posedge ref_clk);
        #1;
        chk_byte(shift_data_reg, d, "data");
        chk_byte({4'h0, count_value}, {4'h0, c}, "count");
        chk_byte({7'h0, count_overflow_flag}, {7'h0, f}, "flag");
    endtask : wait_chk

    initial begin
        {nrst, ctrl_wr, data_wr, stat_wr, timer_match, clock_out_dir, mode1} = 7'h00;
        ovf_irq_en = 1'b1;
        ctrl_wdata = '0;
        stat_wdata = '0;
        data_wdata = 8'h00;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk_byte({count_overflow_flag, ovf_irq, pins}, 8'h00, "reset");
        wait_chk(8'h00, 4'h0, 1'b0);
        // peer clocks a byte in each external mode
        foreach (rows[i]) begin
            mode1 = rows[i].cs[0];
            ctl(rows[i].cs, 1'b0, 1'b0);
            dwr(rows[i].dev_tx);
            swr(4'h0);
            peer.load(rows[i].peer_tx);
            peer.clock_byte();
            wait_chk(rows[i].peer_tx, 4'h0, 1'b1);
            chk_byte(peer.preg, rows[i].dev_tx, "peer rx");
            chk_byte({7'h0, ovf_irq}, 8'h01, "irq");
        end
        // device as master: each strobe toggles its own clock and counts
        mode1 = 1'b0;
        clock_out_dir <= 1'b1;
        dwr(8'hC3);
        swr(4'h0);
        peer.load(8'h5A);
        repeat (16) begin
            ctl(2'h2, 1'b1, 1'b1);
            repeat (3) @(posedge ref_clk);
        end
        wait_chk(8'h5A, 4'h0, 1'b1);
        chk_byte(peer.preg, 8'hC3, "peer rx");
        chk_byte({7'h0, pins.sck_out}, 8'h00, "sck idle");
        // fastest soft clocking: toggle and toggle-plus-clock back to back
        swr(4'h0);
        @(posedge ref_clk);
        ctrl_wr <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            ctrl_wdata <= '{ssu_pkg::WM_THREE, ssu_pkg::CS_SOFT, i[0], 1'b1};
            @(posedge ref_clk);
        end
        ctrl_wr <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk_byte({4'h0, count_value}, 8'h08, "soft count");
        chk_byte({7'h0, pins.sck_out}, 8'h00, "soft sck");
        clock_out_dir <= 1'b0;
        // timer source: wrap at fifteen, collision with a data write
        ctl(ssu_pkg::CS_TIMER, 1'b0, 1'b0);
        dwr(8'h96);
        swr(4'hE);
        tick();
        wait_chk({7'h16, peer_sdi}, 4'hF, 1'b0);
        tick();
        wait_chk({6'h16, peer_sdi, peer_sdi}, 4'h0, 1'b1);
        @(posedge ref_clk);
        data_wr <= 1'b1;
        data_wdata <= 8'h5C;
        timer_match <= 1'b1;
        @(posedge ref_clk);
        data_wr <= 1'b0;
        timer_match <= 1'b0;
        wait_chk(8'h5C, 4'h1, 1'b1);
        ovf_irq_en <= 1'b0;
        wait_chk(8'h5C, 4'h1, 1'b1);
        chk_byte({7'h0, ovf_irq}, 8'h00, "irq masked");
        swr(4'h0);
        wait_chk(8'h5C, 4'h0, 1'b0);
        // two-wire: data falls while clock high, clock held low once it falls
        peer.set_lines(1'b1, 1'b1);
        @(posedge ref_clk);
        ctrl_wr <= 1'b1;
        ctrl_wdata <= '{ssu_pkg::WM_TWO, ssu_pkg::CS_SOFT, 1'b0, 1'b0};
        @(posedge ref_clk);
        ctrl_wr <= 1'b0;
        repeat (4) @(posedge ref_clk);
        peer.set_lines(1'b1, 1'b0);
        repeat (5) @(posedge ref_clk);
        peer.set_lines(1'b0, 1'b0);
        repeat (5) @(posedge ref_clk);
        #1;
        chk_byte({5'h0, start_flag, pins.sck_oe, pins.sck_out}, 8'h06, "start hold");
        @(posedge ref_clk);
        stat_wr <= 1'b1;
        stat_wdata <= '{1'b1, 1'b0, 4'h0};
        @(posedge ref_clk);
        stat_wr <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        chk_byte({5'h0, start_flag, pins.sck_oe, pins.sck_out}, 8'h00, "start release");
        // reset in mid-run clears registers and flags
        @(posedge ref_clk);
        nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk_byte(shift_data_reg, 8'h00, "mid reset data");
        chk_byte({count_value, count_overflow_flag, start_flag, ovf_irq, pins.sck_oe},
            8'h00, "mid reset flags");
        finish_test();
    end
endmodule : serial_shift_unit_three_wire_tb
